// ===== verilog/pch_pkg.sv
/*
 Constants, register map and shared types of the per-axis position counter
 and home search sequencer.
 Assumes one 25 MHz clock, a synchronous active-high reset and a plain
 register port with read data one cycle after the read strobe.
*/
// Summary of operation
// - Logical counter counts every issued drive pulse, up or down by direction.
// - Shown logical position is the counter times pulse multiplier over divisor.
// - Real counter steps on every edge of both encoder phases, four per cycle.
// - Real readout selectable: raw, encoder scaled, or encoder then pulse scaled.
// - Step-out error when logical and encoder-scaled real differ by more than the threshold.
// - Resolution one gives 500 pulses per turn, 0.72 degrees over resolution.
// - Home search runs steps one to four in order, each separately configured.
// - Steps one and four use the fast profile, steps two and three the slow speed.
// - When all steps complete, logical and real position are cleared to zero if clearing is enabled.
// - Steps one, two sense home or limit; step three the index; step four none.
// - Step one drives fast until detection, then decelerates to a stop.
// - Step two drives at constant slow speed and stops at once on detection.
// - Index already active when step three begins gives a search error and end.
// - Limit ahead during step three gives a limit error and ends the search.
// - Step four issues the offset count of pulses fast in its direction.
package pch_pkg;

    // Register byte addresses
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LPOS = 8'h04;
    localparam logic [7:0] OFF_RPOS = 8'h08;
    localparam logic [7:0] OFF_LDISP = 8'h0C;
    localparam logic [7:0] OFF_MODE = 8'h10;
    localparam logic [7:0] OFF_INIT = 8'h14;
    localparam logic [7:0] OFF_FAST = 8'h18;
    localparam logic [7:0] OFF_SLOW = 8'h1C;
    localparam logic [7:0] OFF_OFFSET = 8'h20;
    localparam logic [7:0] OFF_PSCALE = 8'h24;
    localparam logic [7:0] OFF_ESCALE = 8'h28;
    localparam logic [7:0] OFF_STEPTHR = 8'h2C;
    localparam logic [7:0] OFF_STATUS = 8'h30;
    localparam logic [7:0] OFF_ANGLE = 8'h34;

    // Control bits
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;

    // Mode fields
    localparam int MODE_SENSOR = 0;
    localparam int MODE_HOME_LVL = 1;
    localparam int MODE_Z_LVL = 2;
    localparam int MODE_LIM_LVL = 3;
    localparam int MODE_EN = 4;
    localparam int MODE_DIR = 8;
    localparam int MODE_CLEAR = 12;
    localparam int MODE_RSEL = 13;
    localparam int MODE_RES = 16;

    // Status fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_STEP = 1;
    localparam int STAT_HOMEERR = 4;
    localparam int STAT_LIMERR = 5;
    localparam int STAT_STEPOUT = 6;
    localparam int STAT_RUN = 7;
    localparam int STAT_DIR = 8;

    // Reset values
    localparam logic [31:0] MODE_RESET = 32'h0001_1C00;
    localparam logic [15:0] INIT_RESET = 16'h0100;
    localparam logic [15:0] FAST_RESET = 16'h0040;
    localparam logic [15:0] SLOW_RESET = 16'h0200;
    localparam logic [31:0] SCALE_RESET = 32'h0001_0001;
    localparam logic [31:0] STEPTHR_RESET = 32'h0000_0064;

    // Motor geometry
    localparam int PULSES_PER_REV = 500;
    localparam real STEP_ANGLE_DEG = 0.72;
    localparam logic [15:0] CENTIDEG_PER_PULSE =
        16'(int'(STEP_ANGLE_DEG * 100.0));

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pch_bus_s;

    // Sensor pins of the axis
    typedef struct packed {
        logic home;
        logic limPlus;
        logic limMinus;
        logic index;
    } pch_sense_s;

    // Home search sequencer states
    typedef enum logic [2:0] {
        H_IDLE,
        H_NEXT,
        H_ENTER,
        H_RUN,
        H_FINISH
    } pch_home_e;

endpackage

// ===== verilog/pch_quad_decoder.sv
/*
 Quadrature decoder: synchronises the two encoder phases and emits one
 count pulse for each edge of either phase.
 Assumes the phases are asynchronous pins; clk and srst as in the package.
*/
`timescale 1ns/10ps
module pch_quad_decoder (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Encoder phases
    input wire logic encoderPhaseOne,
    input wire logic encoderPhaseTwo,
    // Count pulses
    output logic countUp,
    output logic countDown
);
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] prev;
        logic up;
        logic down;
    } pch_quad_s;

    pch_quad_s q;
    pch_quad_s n;
    logic moved;
    logic ahead;

    // Single-edge step detection, direction from phase order
    always_comb begin
        n = q;
        n.s1 = {encoderPhaseTwo, encoderPhaseOne};
        n.s2 = q.s1;
        n.prev = q.s2;
        moved = ^(q.s2 ^ q.prev);
        ahead = q.s2[0] ^ q.prev[1];
        n.up = moved & ahead;
        n.down = moved & ~ahead;
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign countUp = q.up;
    assign countDown = q.down;
endmodule

// ===== verilog/pch_scaler.sv
/*
 Scaler: multiplies a signed count by a 16-bit multiplier and divides it by a
 16-bit divisor, both packed into one coefficient word (multiplier high).
 Purely combinational; a zero divisor passes the value through.
*/
`timescale 1ns/10ps
module pch_scaler (
    // Value and coefficient pair
    input wire logic signed [31:0] value,
    input wire logic [31:0] coef,
    // Scaled value
    output logic signed [31:0] result
);
    logic signed [48:0] prod;
    logic signed [48:0] quot;

    // Multiply first to keep precision, then divide
    always_comb begin
        prod = value * $signed({1'b0, coef[31:16]});
        quot = prod / $signed({33'h0, coef[15:0]});
        if (coef[15:0] == 16'h0000) begin
            result = value;
        end else begin
            result = quot[31:0];
        end
    end
endmodule

// ===== verilog/pch_position_home.sv
/*
 Axis position tracking and automatic home search sequencer: logical and
 real position counters, scaled readouts, step-out detection and a four
 step home search driving a pulse generator.
 Assumes sensor and encoder pins are asynchronous, one 25 MHz clock and a
 register master that never overlaps read and write strobes.
*/
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module pch_position_home (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire pch_pkg::pch_bus_s bus,
    output logic [31:0] rdData,
    // Sensor and encoder pins
    input wire pch_pkg::pch_sense_s sense,
    input wire logic encoderPhaseOne,
    input wire logic encoderPhaseTwo,
    // Drive path
    output logic drivePulse,
    output logic driveDir,
    // Status
    output logic busy,
    output logic stepOutError
);
    typedef struct packed {
        pch_pkg::pch_home_e hstate;
        logic [2:0] step;
        logic busy;
        logic [31:0] mode;
        logic [15:0] initPer;
        logic [15:0] fastPer;
        logic [15:0] slowPer;
        logic [31:0] offset;
        logic [31:0] pscale;
        logic [31:0] escale;
        logic [31:0] stepThr;
        logic signed [31:0] lpos;
        logic signed [31:0] rpos;
        logic homeErr;
        logic limErr;
        logic stepOut;
        pch_pkg::pch_sense_s sync1;
        pch_pkg::pch_sense_s sync2;
        logic [15:0] timer;
        logic [15:0] period;
        logic [15:0] rampCnt;
        logic [31:0] remain;
        logic running;
        logic fast;
        logic decel;
        logic counted;
        logic dir;
        logic pulse;
        logic [31:0] rdData;
    } pch_main_s;

    pch_main_s q;
    pch_main_s n;

    logic encUp;
    logic encDown;
    logic signed [31:0] lScaled;
    logic signed [31:0] eScaled;
    logic signed [31:0] epScaled;
    logic signed [31:0] angle;
    logic signed [31:0] diff;
    logic [31:0] absDiff;
    logic [31:0] realShown;
    logic [31:0] statusWord;
    logic entryDir;
    logic homeAct;
    logic zAct;
    logic limAhead;
    logic detectHit;
    logic startCmd;
    logic stopCmd;

    // Step enable lookup
    function automatic logic stepOn(input logic [31:0] mode,
                                    input logic [2:0] step);
        stepOn = mode[pch_pkg::MODE_EN + int'(step) - 1];
    endfunction

    // Step direction lookup, high is the plus direction
    function automatic logic stepDirOf(input logic [31:0] mode,
                                       input logic [2:0] step);
        stepDirOf = mode[pch_pkg::MODE_DIR + int'(step) - 1];
    endfunction

    // Encoder edge counting
    pch_quad_decoder quad (
        .clk(clk),
        .srst(srst),
        .encoderPhaseOne(encoderPhaseOne),
        .encoderPhaseTwo(encoderPhaseTwo),
        .countUp(encUp),
        .countDown(encDown)
    );

    // Logical position through the pulse coefficient
    pch_scaler scaleLogical (
        .value(q.lpos),
        .coef(q.pscale),
        .result(lScaled)
    );

    // Real position through the encoder coefficient
    pch_scaler scaleEncoder (
        .value(q.rpos),
        .coef(q.escale),
        .result(eScaled)
    );

    // Encoder-scaled value further through the pulse coefficient
    pch_scaler scaleBoth (
        .value(eScaled),
        .coef(q.pscale),
        .result(epScaled)
    );

    // Motor angle in hundredths of a degree over the step resolution
    pch_scaler scaleAngle (
        .value(q.lpos),
        .coef({pch_pkg::CENTIDEG_PER_PULSE, 12'h000,
               q.mode[pch_pkg::MODE_RES +: 4]}),
        .result(angle)
    );

    // Sensor levels: a level bit of zero means the pin is active low
    always_comb begin
        entryDir = stepDirOf(q.mode, q.step);
        homeAct = q.sync2.home == q.mode[pch_pkg::MODE_HOME_LVL];
        zAct = q.sync2.index == q.mode[pch_pkg::MODE_Z_LVL];
        if (entryDir) begin
            limAhead = q.sync2.limPlus == q.mode[pch_pkg::MODE_LIM_LVL];
        end else begin
            limAhead = q.sync2.limMinus == q.mode[pch_pkg::MODE_LIM_LVL];
        end
        if (q.mode[pch_pkg::MODE_SENSOR]) begin
            detectHit = limAhead;
        end else begin
            detectHit = homeAct;
        end
    end

    // Readout selection and step-out distance
    always_comb begin
        case (q.mode[pch_pkg::MODE_RSEL +: 2])
            2'h1: realShown = eScaled;
            2'h2: realShown = epScaled;
            default: realShown = q.rpos;
        endcase
        diff = q.lpos - eScaled;
        absDiff = diff[31] ? 32'(-diff) : 32'(diff);
        statusWord = 32'h0;
        statusWord[pch_pkg::STAT_BUSY] = q.busy;
        statusWord[pch_pkg::STAT_STEP +: 3] = q.step;
        statusWord[pch_pkg::STAT_HOMEERR] = q.homeErr;
        statusWord[pch_pkg::STAT_LIMERR] = q.limErr;
        statusWord[pch_pkg::STAT_STEPOUT] = q.stepOut;
        statusWord[pch_pkg::STAT_RUN] = q.running;
        statusWord[pch_pkg::STAT_DIR] = q.dir;
    end

    // Control strobes
    assign startCmd = bus.wr && bus.addr == pch_pkg::OFF_CTRL &&
                      bus.wdata[pch_pkg::CTRL_START];
    assign stopCmd = bus.wr && bus.addr == pch_pkg::OFF_CTRL &&
                     bus.wdata[pch_pkg::CTRL_STOP];

    // Next state: registers, counters, pulse generator, sequencer
    always_comb begin
        n = q;
        n.pulse = 1'b0;
        n.rdData = 32'h0;
        n.sync1 = sense;
        n.sync2 = q.sync1;

        // Configuration writes and error clears
        if (bus.wr) begin
            case (bus.addr)
                pch_pkg::OFF_MODE: n.mode = bus.wdata;
                pch_pkg::OFF_INIT: n.initPer = bus.wdata[15:0];
                pch_pkg::OFF_FAST: n.fastPer = bus.wdata[15:0];
                pch_pkg::OFF_SLOW: n.slowPer = bus.wdata[15:0];
                pch_pkg::OFF_OFFSET: n.offset = bus.wdata;
                pch_pkg::OFF_PSCALE: n.pscale = bus.wdata;
                pch_pkg::OFF_ESCALE: n.escale = bus.wdata;
                pch_pkg::OFF_STEPTHR: n.stepThr = bus.wdata;
                pch_pkg::OFF_STATUS: begin
                    if (bus.wdata[pch_pkg::STAT_HOMEERR]) n.homeErr = 1'b0;
                    if (bus.wdata[pch_pkg::STAT_LIMERR]) n.limErr = 1'b0;
                    if (bus.wdata[pch_pkg::STAT_STEPOUT]) n.stepOut = 1'b0;
                end
                default: ;
            endcase
        end

        // Real position follows every encoder edge
        if (encUp) begin
            n.rpos = q.rpos + 32'sd1;
        end else if (encDown) begin
            n.rpos = q.rpos - 32'sd1;
        end

        // Pulse generator with linear period ramp
        if (q.running && q.decel && q.rampCnt == 16'h0000) begin
            n.running = 1'b0;
        end else if (q.running) begin
            if (q.timer == 16'h0000) begin
                n.pulse = 1'b1;
                n.timer = q.period - 16'h0001;
                if (q.dir) begin
                    n.lpos = q.lpos + 32'sd1;
                end else begin
                    n.lpos = q.lpos - 32'sd1;
                end
                if (q.decel) begin
                    n.period = q.period + 16'h0001;
                    n.rampCnt = q.rampCnt - 16'h0001;
                end else if (q.fast && q.period > q.fastPer) begin
                    n.period = q.period - 16'h0001;
                    n.rampCnt = q.rampCnt + 16'h0001;
                end
                if (q.counted) begin
                    n.remain = q.remain - 32'h1;
                    if (q.remain == 32'h1) begin
                        n.running = 1'b0;
                    end else if (q.remain - 32'h1 <= {16'h0, q.rampCnt}) begin
                        n.decel = 1'b1;
                    end
                end
            end else begin
                n.timer = q.timer - 16'h0001;
            end
        end

        // Home search sequencer
        case (q.hstate)
            pch_pkg::H_IDLE: begin
                if (startCmd && !stopCmd) begin
                    n.busy = 1'b1;
                    n.step = 3'h0;
                    n.homeErr = 1'b0;
                    n.limErr = 1'b0;
                    n.hstate = pch_pkg::H_NEXT;
                end
            end
            pch_pkg::H_NEXT: begin
                // One step examined per cycle, disabled ones skipped
                if (q.step == 3'h4) begin
                    n.hstate = pch_pkg::H_FINISH;
                end else begin
                    n.step = q.step + 3'h1;
                    if (stepOn(q.mode, q.step + 3'h1)) begin
                        n.hstate = pch_pkg::H_ENTER;
                    end
                end
            end
            pch_pkg::H_ENTER: begin
                n.dir = entryDir;
                n.decel = 1'b0;
                n.rampCnt = 16'h0000;
                n.counted = 1'b0;
                n.hstate = pch_pkg::H_RUN;
                case (q.step)
                    3'h1: begin
                        if (detectHit || limAhead) begin
                            n.hstate = pch_pkg::H_NEXT;
                        end else begin
                            n.fast = 1'b1;
                            n.running = 1'b1;
                        end
                    end
                    3'h2: begin
                        if (detectHit) begin
                            n.hstate = pch_pkg::H_NEXT;
                        end else begin
                            n.fast = 1'b0;
                            n.running = 1'b1;
                        end
                    end
                    3'h3: begin
                        n.fast = 1'b0;
                        if (zAct) begin
                            n.homeErr = 1'b1;
                            n.busy = 1'b0;
                            n.hstate = pch_pkg::H_IDLE;
                        end else if (limAhead) begin
                            n.limErr = 1'b1;
                            n.busy = 1'b0;
                            n.hstate = pch_pkg::H_IDLE;
                        end else begin
                            n.running = 1'b1;
                        end
                    end
                    default: begin
                        if (q.offset == 32'h0) begin
                            n.hstate = pch_pkg::H_NEXT;
                        end else begin
                            n.fast = 1'b1;
                            n.counted = 1'b1;
                            n.remain = q.offset;
                            n.running = 1'b1;
                        end
                    end
                endcase
                // Fast runs start from the initial period and ramp down
                if (n.fast) begin
                    n.period = q.initPer;
                    n.timer = q.initPer;
                end else begin
                    n.period = q.slowPer;
                    n.timer = q.slowPer;
                end
            end
            pch_pkg::H_RUN: begin
                case (q.step)
                    3'h1: begin
                        if (detectHit || limAhead) begin
                            n.decel = 1'b1;
                        end
                    end
                    3'h2: begin
                        if (detectHit) begin
                            n.running = 1'b0;
                        end
                    end
                    3'h3: begin
                        if (limAhead) begin
                            n.limErr = 1'b1;
                            n.running = 1'b0;
                            n.busy = 1'b0;
                            n.hstate = pch_pkg::H_IDLE;
                        end else if (zAct) begin
                            n.running = 1'b0;
                        end
                    end
                    default: ;
                endcase
                if (!q.running) begin
                    n.hstate = pch_pkg::H_NEXT;
                end
            end
            pch_pkg::H_FINISH: begin
                if (q.mode[pch_pkg::MODE_CLEAR]) begin
                    n.lpos = 32'sd0;
                    n.rpos = 32'sd0;
                end
                n.busy = 1'b0;
                n.hstate = pch_pkg::H_IDLE;
            end
            default: n.hstate = pch_pkg::H_IDLE;
        endcase

        // Software stop ends any run at once
        if (stopCmd) begin
            n.running = 1'b0;
            n.busy = 1'b0;
            n.hstate = pch_pkg::H_IDLE;
        end

        // Step-out check; a set in the cycle of a clear wins
        if (absDiff > q.stepThr) begin
            n.stepOut = 1'b1;
        end

        // Direct position loads win over counting
        if (bus.wr && bus.addr == pch_pkg::OFF_LPOS) begin
            n.lpos = bus.wdata;
        end
        if (bus.wr && bus.addr == pch_pkg::OFF_RPOS) begin
            n.rpos = bus.wdata;
        end

        // Read data for the following cycle
        if (bus.rd) begin
            case (bus.addr)
                pch_pkg::OFF_LPOS: n.rdData = q.lpos;
                pch_pkg::OFF_RPOS: n.rdData = realShown;
                pch_pkg::OFF_LDISP: n.rdData = lScaled;
                pch_pkg::OFF_MODE: n.rdData = q.mode;
                pch_pkg::OFF_INIT: n.rdData = {16'h0, q.initPer};
                pch_pkg::OFF_FAST: n.rdData = {16'h0, q.fastPer};
                pch_pkg::OFF_SLOW: n.rdData = {16'h0, q.slowPer};
                pch_pkg::OFF_OFFSET: n.rdData = q.offset;
                pch_pkg::OFF_PSCALE: n.rdData = q.pscale;
                pch_pkg::OFF_ESCALE: n.rdData = q.escale;
                pch_pkg::OFF_STEPTHR: n.rdData = q.stepThr;
                pch_pkg::OFF_STATUS: n.rdData = statusWord;
                pch_pkg::OFF_ANGLE: n.rdData = angle;
                default: n.rdData = 32'h0;
            endcase
        end
    end

    // State register with documented defaults
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
            q.hstate <= pch_pkg::H_IDLE;
            q.mode <= pch_pkg::MODE_RESET;
            q.initPer <= pch_pkg::INIT_RESET;
            q.fastPer <= pch_pkg::FAST_RESET;
            q.slowPer <= pch_pkg::SLOW_RESET;
            q.pscale <= pch_pkg::SCALE_RESET;
            q.escale <= pch_pkg::SCALE_RESET;
            q.stepThr <= pch_pkg::STEPTHR_RESET;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from the state register
    assign rdData = q.rdData;
    assign drivePulse = q.pulse;
    assign driveDir = q.dir;
    assign busy = q.busy;
    assign stepOutError = q.stepOut;
endmodule

// ===== test/pch_sva.sv
/* Port checker of the axis position and home search block.
 Bound to pch_position_home; one clock, synchronous reset. */
`timescale 1ns/10ps
module pch_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Watched ports
    input wire pch_pkg::pch_bus_s bus,
    input wire logic [31:0] rdData,
    input wire pch_pkg::pch_sense_s sense,
    input wire logic encoderPhaseOne,
    input wire logic encoderPhaseTwo,
    input wire logic drivePulse,
    input wire logic driveDir,
    input wire logic busy,
    input wire logic stepOutError
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Start write and step-out clear write
    wire logic goCmd = bus.wr && bus.addr == pch_pkg::OFF_CTRL
        && bus.wdata[0] && !bus.wdata[1];
    wire logic clrCmd = bus.wr && bus.addr == pch_pkg::OFF_STATUS
        && bus.wdata[6];
    pulse_single_a: assert property (drivePulse |=> !drivePulse)
        else $error("drive pulse wider than one cycle");
    idle_quiet_a: assert property (!busy [*2] |-> !drivePulse)
        else $error("drive pulse while idle");
    start_busy_a: assert property (goCmd |=> busy)
        else $error("start did not raise busy");
    busy_cause_a: assert property (!busy && !goCmd |=> !busy)
        else $error("busy without a start");
    reset_clear_a: assert property (
        $past(srst) |-> !busy && !drivePulse && !stepOutError)
        else $error("outputs not cleared by reset");
    stepout_hold_a: assert property (
        stepOutError && !clrCmd && !goCmd |=> stepOutError)
        else $error("step-out flag dropped");
    rd_quiet_a: assert property (!$past(bus.rd) |-> rdData == '0)
        else $error("read data outside read slot");
    dir_settle_a: assert property (
        $changed(driveDir) |=> !drivePulse)
        else $error("pulse right after direction change");
    cover property ($fell(busy));
    cover property (drivePulse && driveDir);
    cover property ($rose(stepOutError));
endmodule
bind pch_position_home pch_sva u_sva (.clk(clk), .srst(srst), .bus(bus),
    .rdData(rdData), .sense(sense), .encoderPhaseOne(encoderPhaseOne),
    .encoderPhaseTwo(encoderPhaseTwo), .drivePulse(drivePulse),
    .driveDir(driveDir), .busy(busy), .stepOutError(stepOutError));

// ===== test/pch_axis_model.sv
/* Far side of the axis: motor shaft, encoder and sensor pins.
 Assumes each drive pulse moves the shaft by one encoder edge. */
`timescale 1ns/10ps
module pch_axis_model (
    // Clock and drive path
    input wire logic clk,
    input wire logic drivePulse,
    input wire logic driveDir,
    // Sensor places set by the bench
    input wire logic signed [31:0] homeAt,
    input wire logic signed [31:0] idxAt,
    input wire logic signed [31:0] limHi,
    // Encoder and sensor pins
    output logic phaseOne,
    output logic phaseTwo,
    output pch_pkg::pch_sense_s sense
);
    int pos = 0;
    // Shaft follows every drive pulse
    always @(posedge clk) begin
        if (drivePulse) begin
            pos <= driveDir ? pos + 1 : pos - 1;
        end
    end
    // Gray phases, phase one leads going plus
    assign phaseOne = pos[0] ^ pos[1];
    assign phaseTwo = pos[1];
    // Active sensors pull their pins low
    assign sense = '{home: !(pos <= homeAt), limPlus: !(pos >= limHi),
        limMinus: 1'b1, index: !(pos == idxAt)};
endmodule

// ===== test/position_count_home_search_test.sv
/* Bench of the axis position and home search block.
 Drives the register port; the axis model plays motor and sensors. */
`timescale 1ns/10ps
module position_count_home_search_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    pch_pkg::pch_bus_s bus = '0;
    pch_pkg::pch_sense_s sense;
    logic [31:0] rdData, v;
    logic phOne, phTwo, drivePulse, driveDir, busy, stepOutError;
    logic signed [31:0] homeAt = -20, idxAt = 1000, limHi = 1000;
    int error_cnt = 0, checked = 0, cycles = 0, gap = 0, lastGap = 0;
    always #20 clk = ~clk;
    pch_position_home u_pch_position_home (.clk(clk), .srst(srst),
        .bus(bus), .rdData(rdData), .sense(sense), .encoderPhaseOne(phOne),
        .encoderPhaseTwo(phTwo), .drivePulse(drivePulse),
        .driveDir(driveDir), .busy(busy), .stepOutError(stepOutError));
    pch_axis_model u_pch_axis_model (.clk(clk), .drivePulse(drivePulse),
        .driveDir(driveDir), .homeAt(homeAt), .idxAt(idxAt), .limHi(limHi),
        .phaseOne(phOne), .phaseTwo(phTwo), .sense(sense));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Pulse spacing and hang limit
    always @(posedge clk) begin
        cycles++;
        gap++;
        if (drivePulse) begin
            lastGap = gap;
            gap = 0;
        end
        if (cycles == 60000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic check(input string n, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e,
        input string n);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 v = rdData;
        check(n, v, e);
    endtask
    task automatic search(input logic [31:0] mode);
        wrReg(pch_pkg::OFF_MODE, mode);
        wrReg(pch_pkg::OFF_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        while (busy === 1'b1) @(posedge clk);
        repeat (8) @(posedge clk);
    endtask
    // Test sequence
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rdChk(pch_pkg::OFF_MODE, pch_pkg::MODE_RESET, "mode");
        rdChk(8'hFC, 32'h0, "unmapped");
        wrReg(pch_pkg::OFF_INIT, 32'h20);
        wrReg(pch_pkg::OFF_FAST, 32'h4);
        wrReg(pch_pkg::OFF_SLOW, 32'h10);
        wrReg(pch_pkg::OFF_OFFSET, 32'hA);
        wrReg(pch_pkg::OFF_PSCALE, 32'h0003_0002);
        wrReg(pch_pkg::OFF_ESCALE, 32'h0002_0001);
        wrReg(pch_pkg::OFF_STEPTHR, 32'h5);
        check("stepout", {31'h0, stepOutError}, 32'h0);
        search(32'h0001_0880);
        rdChk(pch_pkg::OFF_LPOS, 32'hA, "lpos");
        rdChk(pch_pkg::OFF_LDISP, 32'hF, "ldisp");
        rdChk(pch_pkg::OFF_ANGLE, 32'd720, "angle");
        rdChk(pch_pkg::OFF_RPOS, 32'hA, "raw");
        wrReg(pch_pkg::OFF_MODE, 32'h0001_2880);
        rdChk(pch_pkg::OFF_RPOS, 32'h14, "encscaled");
        wrReg(pch_pkg::OFF_MODE, 32'h0001_4880);
        rdChk(pch_pkg::OFF_RPOS, 32'h1E, "encpulse");
        check("stepout", {31'h0, stepOutError}, 32'h1);
        $display("offset drive test done");
        idxAt = 10;
        search(32'h0001_0440);
        rdChk(pch_pkg::OFF_STATUS, 32'h156, "homeerr");
        idxAt = 1000;
        limHi = 5;
        search(32'h0001_0440);
        rdChk(pch_pkg::OFF_STATUS, 32'h166, "limerr");
        $display("index search error test done");
        limHi = 1000;
        idxAt = -5;
        wrReg(pch_pkg::OFF_OFFSET, 32'h0);
        search(32'h0001_1CF0);
        rdChk(pch_pkg::OFF_LPOS, 32'h0, "cleared");
        rdChk(pch_pkg::OFF_RPOS, 32'h0, "rcleared");
        limHi = u_pch_axis_model.pos + 3;
        search(32'h0001_0221);
        rdChk(pch_pkg::OFF_LPOS, 32'h3, "slowstop");
        check("slowgap", lastGap, 32'd16);
        $display("full search test done");
        final_report();
    end
endmodule
